/* File: rtl/hold_timer.sv */
// Countdown of hold units of 500 us each.
// Assumes load pulses come from the sweep engine.
`timescale 1ns/1ps
module hold_timer
    import sweep_cfg_pkg::*;
#(
    parameter int UNIT_CYC = HOLD_UNIT_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [31:0] units,
    output logic             expired
);
    logic [31:0] unit_reg;
    logic [31:0] cyc_reg;

    // Unit and cycle counters, reloaded on every load
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            unit_reg <= 32'h0;
            cyc_reg  <= 32'h0;
        end
        else if (load)
        begin
            unit_reg <= units;
            cyc_reg  <= 32'(UNIT_CYC - 1);
        end
        else if (unit_reg != 32'h0)
        begin
            if (cyc_reg == 32'h0)
            begin
                unit_reg <= unit_reg - 32'h1;
                cyc_reg  <= 32'(UNIT_CYC - 1);
            end
            else
                cyc_reg <= cyc_reg - 32'h1;
        end
    end

    // Expiry from the counter alone; load depends on it, so no path back
    assign expired = (unit_reg == 32'h0);
endmodule // hold_timer

/* File: rtl/sweep_cfg_device.sv */
// Device end: sweep/list configuration registers and sweep engine.
// Assumes a host on sweep_cfg_if and a synth core on the user ports.
`timescale 1ns/1ps
module sweep_cfg_device
    import sweep_cfg_pkg::*;
#(
    parameter int DEPTH    = TABLE_LAST + 1,
    parameter int UNIT_CYC = HOLD_UNIT_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    sweep_cfg_if.device      bus,
    input  wire logic        use_table,
    input  wire logic        nv_done,
    output logic             nv_store_go,
    output logic             nv_load_go,
    output logic [10:0]      nv_length,
    input  wire logic        nv_wr_en,
    input  wire logic [10:0] nv_wr_addr,
    input  wire logic [55:0] nv_wr_data,
    output logic [55:0]      out_freq,
    output logic             out_phase_neg,
    output logic [14:0]      out_phase_mag,
    output logic             sweep_running,
    output logic [10:0]      point_count
);
    typedef enum {ST_IDLE, ST_RUN} run_t;

    logic [55:0] start_reg, stop_reg, step_reg, tone_reg;
    logic [31:0] hold_reg, repeat_reg, cycles_reg;
    logic [55:0] freq_table [DEPTH];
    logic [31:0] hold_table [DEPTH];
    logic [10:0] wptr_reg, rptr_reg;
    logic        loading_reg, sweep_mode_reg, trig_reg;
    logic        nv_busy_reg;
    logic        hold_load, hold_expired;
    logic [31:0] hold_units;
    logic [55:0] freq_reg;
    run_t        state_reg;
    logic        wr;
    logic [55:0] d;
    logic        at_end;
    logic [10:0] next_ptr;

    assign wr           = bus.wr_valid && bus.wr_ready;
    assign d            = bus.wr_data;
    assign bus.wr_ready = !nv_busy_reg;

    // ========================================================
    // Scalar configuration registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            start_reg      <= WORD_RESET;
            stop_reg       <= WORD_RESET;
            step_reg       <= WORD_RESET;
            hold_reg       <= 32'h0;
            repeat_reg     <= 32'h0;
            tone_reg       <= WORD_RESET;
            out_phase_mag  <= 15'h0;
            out_phase_neg  <= 1'b0;
            sweep_mode_reg <= 1'b0;
        end
        else if (wr)
        begin
            case (bus.wr_addr)
                OFF_START: start_reg <= d;
                OFF_STOP:  stop_reg <= d;
                OFF_STEP:  step_reg <= d;
                OFF_HOLD:  hold_reg <= d[HOLD_WIDTH-1:0];
                OFF_REPEAT: repeat_reg <= d[31:0];
                OFF_TONE_FREQ:
                    if (!sweep_mode_reg)
                        tone_reg <= d;
                OFF_PHASE:
                begin
                    out_phase_mag <= d[PHASE_MAG_WIDTH-1:0];
                    out_phase_neg <= d[PHASE_SIGN_BIT];
                end
                OFF_MODE: sweep_mode_reg <= d[MODE_SWEEP_BIT];
                default: ;
            endcase
        end
    end

    // ========================================================
    // Table loading pointer and point count
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wptr_reg    <= 11'h0;
            loading_reg <= 1'b0;
            point_count <= 11'h0;
        end
        else if (wr && bus.wr_addr == OFF_LOAD)
        begin
            if (d == LOAD_RESTART)
            begin
                wptr_reg    <= 11'h0;
                loading_reg <= 1'b1;
            end
            else if (d == LOAD_END)
            begin
                loading_reg <= 1'b0;
                point_count <= wptr_reg;
            end
            else if (loading_reg && wptr_reg != 11'(TABLE_LAST))
                wptr_reg <= wptr_reg + 11'h1;
        end
    end

    // Table storage, from host port or NV restore
    always_ff @(posedge sys_clk)
    begin
        if (wr && bus.wr_addr == OFF_LOAD && loading_reg && d != LOAD_RESTART
            && d != LOAD_END && wptr_reg != 11'(TABLE_LAST))
        begin
            if (d[LOAD_SEL_BIT])
                hold_table[wptr_reg] <= d[31:0];
            else
                freq_table[wptr_reg] <= {1'b0, d[54:0]};
        end
        else if (nv_wr_en)
            freq_table[nv_wr_addr] <= nv_wr_data;
    end

    // ========================================================
    // Non-volatile copy requests
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            nv_store_go <= 1'b0;
            nv_load_go  <= 1'b0;
            nv_busy_reg <= 1'b0;
            nv_length   <= 11'h0;
        end
        else
        begin
            nv_store_go <= wr && bus.wr_addr == OFF_NV_COPY && !d[COPY_DIR_BIT];
            nv_load_go  <= wr && bus.wr_addr == OFF_NV_COPY && d[COPY_DIR_BIT];
            nv_length   <= point_count;
            if (wr && bus.wr_addr == OFF_NV_COPY)
                nv_busy_reg <= 1'b1;
            else if (nv_done)
                nv_busy_reg <= 1'b0;
        end
    end

    // Soft trigger pulse, only in sweep mode
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            trig_reg <= 1'b0;
        else
            trig_reg <= wr && bus.wr_addr == OFF_SOFT_TRIG && sweep_mode_reg;
    end

    // ========================================================
    // Sweep engine
    // Hold of the point being entered: next index, or index 0 on a start or on a wrap at the end
    assign at_end     = use_table ? (rptr_reg + 11'h1 >= point_count)
                                  : (freq_reg + step_reg > stop_reg);
    assign next_ptr   = (state_reg == ST_RUN && !at_end) ? rptr_reg + 11'h1 : 11'h0;
    assign hold_units = (use_table && point_count != 11'h0)
                        ? hold_table[next_ptr] : hold_reg;
    assign hold_load  = state_reg == ST_RUN && hold_expired;

    hold_timer #(.UNIT_CYC(UNIT_CYC)) u_hold
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (hold_load || trig_reg),
        .units   (hold_units),
        .expired (hold_expired)
    );

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg  <= ST_IDLE;
            rptr_reg   <= 11'h0;
            freq_reg   <= WORD_RESET;
            cycles_reg <= 32'h0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (trig_reg)
                    begin
                        state_reg  <= ST_RUN;
                        rptr_reg   <= 11'h0;
                        cycles_reg <= 32'h0;
                        freq_reg   <= use_table ? freq_table[0] : start_reg;
                    end
                ST_RUN:
                    if (trig_reg || !sweep_mode_reg)
                        state_reg <= ST_IDLE;
                    else if (hold_expired)
                    begin
                        if (at_end)
                        begin
                            cycles_reg <= cycles_reg + 32'h1;
                            rptr_reg   <= 11'h0;
                            freq_reg   <= use_table ? freq_table[0] : start_reg;
                            if (repeat_reg != 32'h0 && cycles_reg + 32'h1 == repeat_reg)
                                state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            rptr_reg <= rptr_reg + 11'h1;
                            freq_reg <= use_table ? freq_table[rptr_reg + 11'h1]
                                                  : freq_reg + step_reg;
                        end
                    end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign out_freq      = sweep_mode_reg ? freq_reg : tone_reg;
    assign sweep_running = state_reg == ST_RUN;
endmodule // sweep_cfg_device

/* File: rtl/sweep_cfg_host.sv */
// Host end: turns user write requests into link writes.
// Assumes the device end on sweep_cfg_if.
`timescale 1ns/1ps
module sweep_cfg_host
    import sweep_cfg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    sweep_cfg_if.host        bus,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_addr,
    input  wire logic [55:0] req_data,
    output logic [14:0]      phase_now
);
    logic [55:0]        data_next;
    logic [14:0]        tgt_mag;
    logic [14:0]        nxt_mag;
    logic               phase_seq;
    logic               neg_reg;
    logic signed [16:0] cur_s;
    logic signed [16:0] tgt_s;
    logic signed [16:0] nxt_s;
    logic signed [16:0] step_s;

    // Signed phase last sent on the link
    assign step_s = $signed({2'b00, PHASE_STEP_DEG});
    assign cur_s  = neg_reg ? -$signed({2'b00, phase_now}) : $signed({2'b00, phase_now});

    // Phase target clamped and stepped in 90 degree increments either way
    always_comb
    begin
        tgt_mag   = req_data[14:0] > PHASE_MAX_DEG ? PHASE_MAX_DEG : req_data[14:0];
        tgt_s     = req_data[15] ? -$signed({2'b00, tgt_mag}) : $signed({2'b00, tgt_mag});
        nxt_s     = tgt_s;
        phase_seq = 1'b0;
        if (tgt_s - cur_s > step_s)
        begin
            nxt_s     = cur_s + step_s;
            phase_seq = req_addr == OFF_PHASE;
        end
        else if (cur_s - tgt_s > step_s)
        begin
            nxt_s     = cur_s - step_s;
            phase_seq = req_addr == OFF_PHASE;
        end
        nxt_mag   = nxt_s < 0 ? 15'(-nxt_s) : 15'(nxt_s);
        data_next = req_data;
        if (req_addr == OFF_SOFT_TRIG)
            data_next = WORD_RESET;
        else if (req_addr == OFF_HOLD || req_addr == OFF_REPEAT)
            data_next = {24'h0, req_data[31:0]};
        else if (req_addr == OFF_PHASE)
            data_next = {40'h0, nxt_s < 0, nxt_mag};
    end

    // Link drive; a stepped phase holds the request until done
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bus.wr_valid <= 1'b0;
            bus.wr_addr  <= 8'h0;
            bus.wr_data  <= WORD_RESET;
            phase_now    <= 15'h0;
            neg_reg      <= 1'b0;
        end
        else if (!bus.wr_valid || bus.wr_ready)
        begin
            bus.wr_valid <= req_valid;
            bus.wr_addr  <= req_addr;
            bus.wr_data  <= data_next;
            if (req_valid && req_addr == OFF_PHASE)
            begin
                phase_now <= nxt_mag;
                neg_reg   <= nxt_s < 0;
            end
        end
    end

    // user must order start below stop, step within span
    assign req_ready = (!bus.wr_valid || bus.wr_ready) && !phase_seq;
endmodule // sweep_cfg_host

/* File: rtl/sweep_cfg_if.sv */
// Write-only register link from host to sweep device.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface sweep_cfg_if;
    logic        wr_valid;
    logic        wr_ready;
    logic [7:0]  wr_addr;
    logic [55:0] wr_data;
    modport host   (output wr_valid, output wr_addr, output wr_data, input wr_ready);
    modport device (input wr_valid, input wr_addr, input wr_data, output wr_ready);
endinterface

/* File: rtl/sweep_cfg_pkg.sv */
// Shared constants for the sweep/list configuration link.
// Assumes one 100 MHz clock shared by host and device ends.
package sweep_cfg_pkg;
    // ========================================================
    // Register offsets
    localparam logic [7:0] OFF_START      = 8'h06;
    localparam logic [7:0] OFF_STOP       = 8'h07;
    localparam logic [7:0] OFF_STEP       = 8'h08;
    localparam logic [7:0] OFF_HOLD       = 8'h09;
    localparam logic [7:0] OFF_REPEAT     = 8'h0a;
    localparam logic [7:0] OFF_LOAD       = 8'h0b;
    localparam logic [7:0] OFF_NV_COPY    = 8'h0c;
    localparam logic [7:0] OFF_SOFT_TRIG  = 8'h0f;
    localparam logic [7:0] OFF_TONE_FREQ  = 8'h10;
    localparam logic [7:0] OFF_PHASE      = 8'h11;
    localparam logic [7:0] OFF_MODE       = 8'h14;
    // ========================================================
    // Field positions
    localparam int LOAD_SEL_BIT    = 55;
    localparam int COPY_DIR_BIT    = 0;
    localparam int PHASE_SIGN_BIT  = 15;
    localparam int MODE_SWEEP_BIT  = 0;
    localparam int HOLD_WIDTH      = 32;
    localparam int PHASE_MAG_WIDTH = 15;
    // ========================================================
    // Special values
    localparam logic [55:0] LOAD_RESTART   = 56'h0;
    localparam logic [55:0] LOAD_END       = 56'hffffffffffffff; // All ones across the word
    localparam int          TABLE_LAST     = 2047;
    localparam logic [14:0] PHASE_MAX_DEG  = 15'h0168;
    localparam logic [14:0] PHASE_STEP_DEG = 15'h005a;
    // ========================================================
    // Timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int HOLD_UNIT_US   = 500;
    localparam int HOLD_UNIT_CYC  = CLK_HZ / 1_000_000 * HOLD_UNIT_US;
    localparam logic [55:0] WORD_RESET = 56'h0;
endpackage

/* File: tb/sweep_cfg_chk.sv */
// Checker on the host-to-device write link.
// Assumes the bench instantiates it beside the link.
`timescale 1ns/1ps
module sweep_cfg_chk
    import sweep_cfg_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire logic [7:0]  wr_addr,
    input wire logic [55:0] wr_data
);
    logic               take;
    logic [55:0]        start_reg;
    logic [55:0]        stop_reg;
    logic signed [16:0] phase_reg;
    logic signed [16:0] phase_next;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ========================================================
    // Helpers
    // Accepted write and its signed phase
    assign take = wr_valid && wr_ready;
    assign phase_next = wr_data[15] ? -$signed({2'b00, wr_data[14:0]})
                                    : $signed({2'b00, wr_data[14:0]});
    // Last start, stop and phase written
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            start_reg <= 56'h0;
            stop_reg  <= 56'h0;
            phase_reg <= 17'sh0;
        end
        else if (take)
        begin
            case (wr_addr)
                OFF_START: start_reg <= wr_data;
                OFF_STOP:  stop_reg  <= wr_data;
                OFF_PHASE: phase_reg <= phase_next;
                default:   ;
            endcase
        end
    end
    // ========================================================
    // Assertions
    stop_above_start_a: assert property (take && wr_addr == OFF_STOP |->
        wr_data > start_reg) else $error("stop not above start");
    step_in_span_a: assert property (take && wr_addr == OFF_STEP |->
        wr_data <= stop_reg - start_reg) else $error("step wider than span");
    hold_upper_a: assert property (take && wr_addr == OFF_HOLD |->
        wr_data[55:32] == 24'h0) else $error("hold upper bits set");
    count_upper_a: assert property (take && wr_addr == OFF_REPEAT |->
        wr_data[55:32] == 24'h0) else $error("count upper bits set");
    copy_blocks_ready_a: assert property (take && wr_addr == OFF_NV_COPY |=> !wr_ready)
        else $error("ready during copy");
    copy_reserved_a: assert property (take && wr_addr == OFF_NV_COPY |->
        wr_data[55:1] == 55'h0) else $error("copy reserved bits set");
    trig_data_zero_a: assert property (take && wr_addr == OFF_SOFT_TRIG |->
        wr_data == 56'h0) else $error("trigger data not zero");
    phase_range_a: assert property (take && wr_addr == OFF_PHASE |->
        wr_data[14:0] <= PHASE_MAX_DEG) else $error("phase above range");
    phase_step_a: assert property (take && wr_addr == OFF_PHASE |->
        (phase_next - phase_reg <= 90) && (phase_next - phase_reg >= -90))
        else $error("phase jump too large");
    write_held_a: assert property (wr_valid && !wr_ready |=>
        wr_valid && $stable(wr_addr) && $stable(wr_data)) else $error("write dropped");
    cover property (take && wr_addr == OFF_NV_COPY);
    cover property (take && wr_addr == OFF_SOFT_TRIG);
    cover property (take && wr_addr == OFF_LOAD && wr_data == LOAD_END);
endmodule // sweep_cfg_chk

/* File: tb/sweep_list_config_registers_tb.sv */
// Bench joining host and device ends over the write link.
// Assumes rtl package, link and both ends compiled first.
`timescale 1ns/1ps
module sweep_list_config_registers_tb
    import sweep_cfg_pkg::*;
;
    localparam int UC = 4;
    logic        sys_clk, rst, req_valid, req_ready, use_table, nv_done, nv_store_go;
    logic        nv_load_go, nv_wr_en, ld_q, out_phase_neg, sweep_running;
    logic [7:0]  req_addr;
    logic [55:0] req_data, out_freq, tone;
    logic [14:0] out_phase_mag, ph, ph_now;
    logic [10:0] nv_length, point_count, last_len;
    logic [2:0]  nv_dly;
    int          failures, checks_done, cycles, seed, stores, loads, run_len;
    sweep_cfg_if link();
    sweep_cfg_host i_sweep_cfg_host (.sys_clk(sys_clk), .rst(rst), .bus(link.host),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_data(req_data), .phase_now(ph_now));
    sweep_cfg_device #(.UNIT_CYC(UC)) i_sweep_cfg_device (.sys_clk(sys_clk), .rst(rst),
        .bus(link.device), .use_table(use_table), .nv_done(nv_done),
        .nv_store_go(nv_store_go), .nv_load_go(nv_load_go), .nv_length(nv_length),
        .nv_wr_en(nv_wr_en), .nv_wr_addr({8'h00, nv_dly}), .nv_wr_data({53'h0, nv_dly}),
        .out_freq(out_freq), .out_phase_neg(out_phase_neg), .out_phase_mag(out_phase_mag),
        .sweep_running(sweep_running), .point_count(point_count));
    sweep_cfg_chk i_sweep_cfg_chk (.sys_clk(sys_clk), .rst(rst), .wr_valid(link.wr_valid),
        .wr_ready(link.wr_ready), .wr_addr(link.wr_addr), .wr_data(link.wr_data));
    // ========================================================
    // Clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Timeout, copy responder and monitors
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        nv_dly <= {nv_dly[1:0], nv_store_go | nv_load_go};
        nv_done <= nv_dly[2];
        ld_q <= nv_load_go;
        nv_wr_en <= ld_q; // Restore writes follow a load
        if (nv_store_go === 1'b1)
        begin
            stores++;
            last_len <= nv_length;
        end
        if (nv_load_go === 1'b1)
            loads++;
        if (sweep_running === 1'b1)
            run_len++;
        if (cycles == 40000)
        begin
            failures++;
            end_sim();
        end
    end
    // ========================================================
    // Tasks
    task automatic chk(input string nm, input logic [55:0] seen, input logic [55:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One link write through the host, held until taken
    task automatic wr(input logic [7:0] a, input logic [55:0] d);
        req_valid <= 1'b1;
        req_addr <= a;
        req_data <= d;
        do
            @(posedge sys_clk);
        while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    function automatic int run_cyc(input int pts, input int hold);
        return pts * hold * UC;
    endfunction
    // Run length inside a small window above the ideal count
    function automatic bit in_win(input int n, input int lo);
        return n >= lo && n <= lo + 8;
    endfunction
    // ========================================================
    // Main sequence
    initial
    begin
        {seed, failures, checks_done, cycles, stores, loads, run_len} = {32'd97, 192'h0};
        {rst, req_valid, use_table, nv_done, nv_wr_en, ld_q} = 6'b100000;
        {req_addr, req_data, nv_dly, last_len} = 78'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // Random tones and phases
        for (int i = 0; i < 6; i++)
        begin
            tone = 56'({$random(seed), $random(seed)});
            ph = 15'($unsigned($random(seed)) % 361);
            wr(OFF_TONE_FREQ, tone);
            wr(OFF_PHASE, {41'h0, ph});
            idle(40);
            chk("tone", out_freq, tone);
            chk("phase_mag", 56'(out_phase_mag), 56'(ph));
            chk("phase_now", 56'(ph_now), 56'(ph));
        end
        wr(OFF_PHASE, 56'h0);
        wr(OFF_PHASE, 56'h802d);
        idle(40);
        chk("phase_neg", 56'({out_phase_neg, out_phase_mag}), 56'h802d);
        // Table overfilled, then reloaded with five points
        wr(OFF_LOAD, LOAD_RESTART);
        repeat (2100) wr(OFF_LOAD, 56'h1234);
        wr(OFF_LOAD, LOAD_END);
        idle(2);
        chk("count_sat", 56'(point_count), 56'd2047);
        wr(OFF_LOAD, LOAD_RESTART);
        for (int i = 1; i <= 5; i++)
            wr(OFF_LOAD, 56'(100 + i));
        wr(OFF_LOAD, LOAD_END);
        wr(OFF_LOAD, 56'h77);
        wr(OFF_LOAD, LOAD_END);
        idle(2);
        chk("count_five", 56'(point_count), 56'd5);
        // Copies in both directions
        wr(OFF_NV_COPY, 56'h0);
        idle(10);
        chk("store", {stores[7:0], 37'h0, last_len}, {8'd1, 37'h0, 11'd5});
        wr(OFF_NV_COPY, 56'h1);
        idle(10);
        chk("load", 56'(loads), 56'd1);
        // Computed sweep of four points, one cycle
        wr(OFF_START, 56'd100);
        wr(OFF_STOP, 56'd103);
        wr(OFF_STEP, 56'd1);
        wr(OFF_HOLD, 56'd2);
        wr(OFF_REPEAT, 56'd1);
        wr(OFF_SOFT_TRIG, 56'h0);
        idle(5);
        chk("trig_tone_mode", 56'(sweep_running), 56'h0);
        wr(OFF_MODE, 56'h1);
        wr(OFF_TONE_FREQ, 56'h55);
        run_len = 0;
        wr(OFF_SOFT_TRIG, 56'h0);
        idle(2);
        chk("running", 56'(sweep_running), 56'h1);
        while (sweep_running !== 1'b0)
            @(posedge sys_clk);
        chk("run_len", 56'(in_win(run_len, run_cyc(4, 2))), 56'h1);
        // Table sweep: frequencies, then holds at the same two indices
        wr(OFF_LOAD, LOAD_RESTART);
        wr(OFF_LOAD, 56'd300);
        wr(OFF_LOAD, 56'd301);
        wr(OFF_LOAD, LOAD_END);
        wr(OFF_LOAD, LOAD_RESTART);
        repeat (2) wr(OFF_LOAD, {1'b1, 55'h1});
        wr(OFF_LOAD, LOAD_END);
        use_table <= 1'b1;
        run_len = 0;
        wr(OFF_SOFT_TRIG, 56'h0);
        idle(2);
        chk("table_first", out_freq, 56'd300);
        while (sweep_running !== 1'b0)
            @(posedge sys_clk);
        chk("table_len", 56'(in_win(run_len, run_cyc(2, 1))), 56'h1);
        use_table <= 1'b0;
        // Endless repeat, stopped by a second trigger
        wr(OFF_REPEAT, 56'h0);
        wr(OFF_SOFT_TRIG, 56'h0);
        idle(300);
        chk("endless", 56'(sweep_running), 56'h1);
        wr(OFF_SOFT_TRIG, 56'h0);
        idle(5);
        chk("stopped", 56'(sweep_running), 56'h0);
        wr(OFF_MODE, 56'h0);
        idle(2);
        chk("tone_kept", out_freq, tone);
        end_sim();
    end
endmodule // sweep_list_config_registers_tb
